//--- logic/dhm_top.sv
`timescale 1ns/10ps
// Operation
// - Report method one sends predictive-failure sense with failure type in unit code.
// - Predictive error code is held in a retained register surviving bus reset.
// - Each attribute keeps an operation interval counter and an error counter.
// - Errors above threshold before interval end mean unacceptable, else acceptable.
// - Both counters clear after every classification, starting a new interval.
// - History counter rises on unacceptable, falls on acceptable, floored at zero.
// - History reaching predictive threshold signals failure; one counter per attribute.
// - Temperature is sampled at power-up and every ten minutes.
// - Sampled temperature above a trip point produces warning sense code.
// - Measured temperature goes into the unit code field of the sense.
// - Temperature warnings gated by warning enable and delivered per report method.
// - Fixed trip at 68 C plus programmable trip defaulting to 68 C.
// - Programmable trip above 68 C is clamped and a rounding sense is sent.
// - Temperature log gives current temperature and reference temperature by code.
// - Self-test function code from byte 1 bits 7:5: short or extended.
// - Short self-test ends within 120 seconds.
// - Each self-test runs electrical, servo and read/verify segments in order.
// - Starting a test pushes a log entry at head; 20 entries kept.
// - New entry copies function code, result Fh, and is flagged for storing.
// - Completion or abort writes 4-bit result; zero is pass.
// - Function-code abort records 01; reset abort records 02.
// - Motor, servo or table failures answer readiness query with not-ready codes.
// - Exception disable stops all predictive monitoring.
module dhm_top
  import dhm_pkg::*;
#(
  parameter logic [CNT_W-1:0]  INTERVAL_LEN  = 16'h0400,
  parameter logic [CNT_W-1:0]  ERR_THRESH    = 16'h0010,
  parameter logic [HIST_W-1:0] PRED_THRESH   = 8'h08,
  parameter longint            TEMP_PERIOD   = TEMP_PERIOD_CYC,
  parameter longint            SHORT_LIMIT   = SHORT_LIMIT_CYC,
  parameter logic [31:0]       SEG_CYC_SHORT = 32'h0000_1000,
  parameter logic [31:0]       SEG_CYC_EXT   = 32'h0001_0000
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  bus_reset_i,
  input  wire logic [NUM_ATTR-1:0]   op_done_i,
  input  wire logic [NUM_ATTR-1:0]   op_err_i,
  input  wire logic                  exception_disable_i,
  input  wire logic                  warning_enable_i,
  input  wire logic [2:0]            report_method_field_i,
  input  wire logic [TEMP_W-1:0]     temp_i,
  input  wire logic                  ref_wr_i,
  input  wire logic [TEMP_W-1:0]     ref_wdata_i,
  input  wire logic [15:0]           tlog_code_i,
  input  wire logic                  diag_cmd_i,
  input  wire logic [7:0]            diag_byte1_i,
  input  wire logic                  seg_fail_i,
  input  wire logic                  motor_fail_i,
  input  wire logic                  servo_fail_i,
  input  wire logic                  table_fail_i,
  input  wire logic [4:0]            log_idx_i,
  output logic                       pred_fail_o,
  output logic [NUM_ATTR-1:0]        pred_attr_o,
  output dhm_sense_t                 sense_o,
  output logic [TEMP_W-1:0]          tlog_data_o,
  output logic [TEMP_W-1:0]          ref_temp_o,
  output logic                       test_busy_o,
  output dhm_state_t                 test_state_o,
  output dhm_log_t                   log_entry_o,
  output logic                       log_store_o,
  output logic [23:0]                ready_code_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Rate monitoring per attribute.
  logic [CNT_W-1:0]  ivl_q [NUM_ATTR];
  logic [CNT_W-1:0]  ivl_d [NUM_ATTR];
  logic [CNT_W-1:0]  fail_q [NUM_ATTR];
  logic [CNT_W-1:0]  fail_d [NUM_ATTR];
  logic [HIST_W-1:0] hist_q [NUM_ATTR];
  logic [HIST_W-1:0] hist_d [NUM_ATTR];
  logic [NUM_ATTR-1:0] pred_q, pred_d;
  // Held apart from bus reset so a reported code is never lost there.
  logic [NUM_ATTR-1:0] kept_q, kept_d;

  always_comb begin
    for (int a = 0; a < NUM_ATTR; a++) begin
      ivl_d[a]  = ivl_q[a];
      fail_d[a] = fail_q[a];
      hist_d[a] = hist_q[a];
      if (!exception_disable_i && op_done_i[a]) begin
        ivl_d[a] = CNT_W'(ivl_q[a] + 1'b1);
        if (op_err_i[a]) begin
          fail_d[a] = CNT_W'(fail_q[a] + 1'b1);
        end
        if (fail_d[a] > ERR_THRESH) begin
          ivl_d[a]  = '0;
          fail_d[a] = '0;
          if (hist_q[a] != {HIST_W{1'b1}}) begin
            hist_d[a] = HIST_W'(hist_q[a] + 1'b1);
          end
        end else if (ivl_d[a] >= INTERVAL_LEN) begin
          ivl_d[a]  = '0;
          fail_d[a] = '0;
          if (hist_q[a] != '0) begin
            hist_d[a] = HIST_W'(hist_q[a] - 1'b1);
          end
        end
      end
      pred_d[a] = !exception_disable_i && (hist_d[a] >= PRED_THRESH);
    end
    kept_d = kept_q | pred_d;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int a = 0; a < NUM_ATTR; a++) begin
        ivl_q[a]  <= '0;
        fail_q[a] <= '0;
        hist_q[a] <= '0;
      end
      pred_q <= '0;
      kept_q <= '0;
    end else begin
      ivl_q  <= ivl_d;
      fail_q <= fail_d;
      hist_q <= hist_d;
      pred_q <= pred_d;
      kept_q <= kept_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Thermal monitor.
  logic [TEMP_W-1:0] t_s1_q, t_s2_q, t_s3_q, t_stable_q, t_stable_d;
  logic [TEMP_W-1:0] temp_q, temp_d, ref_q, ref_d;
  logic [63:0]       tcnt_q, tcnt_d;
  logic              sample_q, sample_d, round_q, round_d;

  always_comb begin
    t_stable_d = (t_s2_q == t_s3_q) ? t_s3_q : t_stable_q;
    sample_d   = 1'b0;
    tcnt_d     = tcnt_q + 64'h1;
    if (tcnt_q >= 64'(TEMP_PERIOD - 1)) begin
      tcnt_d   = '0;
      sample_d = 1'b1;
    end
    temp_d = sample_q ? t_stable_q : temp_q;
    ref_d   = ref_q;
    round_d = 1'b0;
    if (ref_wr_i) begin
      if (ref_wdata_i > TRIP_FIXED_C) begin
        ref_d   = TRIP_FIXED_C;
        round_d = 1'b1;
      end else begin
        ref_d = ref_wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    t_s1_q <= temp_i;
    t_s2_q <= t_s1_q;
    t_s3_q <= t_s2_q;
    if (rst_i) begin
      t_stable_q <= '0;
      tcnt_q     <= 64'(TEMP_PERIOD - 8);
      sample_q   <= 1'b0;
      temp_q     <= '0;
      ref_q      <= TRIP_DEFAULT_C;
      round_q    <= 1'b0;
    end else begin
      t_stable_q <= t_stable_d;
      tcnt_q     <= tcnt_d;
      sample_q   <= sample_d;
      temp_q     <= temp_d;
      ref_q      <= ref_d;
      round_q    <= round_d;
    end
  end

  wire temp_hot = sample_q && ((t_stable_q > TRIP_FIXED_C) || (t_stable_q > ref_q));

  ////////////////////////////////////////////////////////////////////////////
  // Self-test sequencer and results log.
  dhm_state_t st_q, st_d;
  logic [2:0]  func_q, func_d;
  logic [31:0] seg_q, seg_d;
  logic [63:0] run_q, run_d;
  dhm_log_t    log_q [LOG_DEPTH];
  logic        push, fin, store_d, store_q;
  logic [3:0]  fin_res;
  logic [2:0]  req;

  assign req = diag_byte1_i[FUNC_LSB +: 3];

  always_comb begin
    st_d    = st_q;
    func_d  = func_q;
    seg_d   = 32'(seg_q + 1'b1);
    run_d   = run_q + 64'h1;
    push    = 1'b0;
    fin     = 1'b0;
    fin_res = RES_PASS;
    case (st_q)
      ST_IDLE: begin
        seg_d = '0;
        run_d = '0;
        if (diag_cmd_i && (req == FUNC_SHORT || req == FUNC_EXTENDED)) begin
          func_d = req;
          push   = 1'b1;
          st_d   = ST_ELEC;
        end
      end
      ST_ELEC, ST_SERVO, ST_SCAN: begin
        if (bus_reset_i) begin
          fin = 1'b1;
          fin_res = RES_ABORT_RESET;
        end else if (diag_cmd_i && req == FUNC_ABORT) begin
          fin = 1'b1;
          fin_res = RES_ABORT_APP;
        end else if (seg_fail_i) begin
          fin = 1'b1;
          fin_res = RES_SEG_FAIL;
        end else if (func_q == FUNC_SHORT && run_q >= 64'(SHORT_LIMIT - 1)) begin
          fin = 1'b1;
        end else if (seg_q >= ((func_q == FUNC_SHORT) ? SEG_CYC_SHORT : SEG_CYC_EXT)) begin
          seg_d = '0;
          case (st_q)
            ST_ELEC:  st_d = ST_SERVO;
            ST_SERVO: st_d = ST_SCAN;
            default:  fin  = 1'b1;
          endcase
        end
        if (fin) begin
          st_d = ST_DONE;
        end
      end
      ST_DONE: st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
    store_d = push || fin;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q    <= ST_IDLE;
      func_q  <= '0;
      seg_q   <= '0;
      run_q   <= '0;
      store_q <= 1'b0;
      for (int i = 0; i < LOG_DEPTH; i++) begin
        log_q[i] <= '0;
      end
    end else begin
      st_q    <= st_d;
      func_q  <= func_d;
      seg_q   <= seg_d;
      run_q   <= run_d;
      store_q <= store_d;
      if (push) begin
        for (int i = LOG_DEPTH - 1; i > 0; i--) begin
          log_q[i] <= log_q[i-1];
        end
        log_q[0] <= '{func: req, result: RES_IN_PROGRESS};
      end else if (fin) begin
        log_q[0].result <= fin_res;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  dhm_sense_t sense_d;
  always_comb begin
    sense_d = '0;
    if (round_q) begin
      sense_d = '{valid: 1'b1, code: SENSE_ROUNDED, unit_code: ref_q};
    end else if (temp_hot && warning_enable_i && report_method_field_i != '0) begin
      sense_d = '{valid: 1'b1, code: SENSE_TEMP_WARN, unit_code: t_stable_q};
    end else if (|(pred_d & ~pred_q) && report_method_field_i == REPORT_PREDICT) begin
      sense_d.valid = 1'b1;
      sense_d.code  = SENSE_PREDICT;
      for (int a = NUM_ATTR - 1; a >= 0; a--) begin
        if (pred_d[a] && !pred_q[a]) sense_d.unit_code = 8'(a + 1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sense_o      <= '0;
      pred_fail_o  <= 1'b0;
      pred_attr_o  <= '0;
      tlog_data_o  <= '0;
      ref_temp_o   <= TRIP_DEFAULT_C;
      test_busy_o  <= 1'b0;
      test_state_o <= ST_IDLE;
      log_entry_o  <= '0;
      log_store_o  <= 1'b0;
      ready_code_o <= '0;
    end else begin
      sense_o      <= sense_d;
      pred_fail_o  <= |pred_d;
      pred_attr_o  <= kept_d;
      tlog_data_o  <= (tlog_code_i == TLOG_REF_TEMP) ? ref_q :
                      (tlog_code_i == TLOG_CUR_TEMP) ? temp_q : '0;
      ref_temp_o   <= ref_q;
      test_busy_o  <= (st_d != ST_IDLE) && (st_d != ST_DONE);
      test_state_o <= st_d;
      log_entry_o  <= (log_idx_i < 5'(LOG_DEPTH)) ? log_q[log_idx_i] : '0;
      log_store_o  <= store_d;
      ready_code_o <= (motor_fail_i || table_fail_i) ? SENSE_NOT_READY :
                      servo_fail_i ? SENSE_NOT_READY_3 : 24'h000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_HIST_FLOOR: assert property (@(posedge clk_i) disable iff (rst_i)
    hist_q[1] == '0 |=> hist_q[1] <= 8'h01) else $error("history went below zero");
  AST_PRED: assert property (@(posedge clk_i) disable iff (rst_i)
    (hist_d[1] >= PRED_THRESH && !exception_disable_i) |=> pred_fail_o)
    else $error("predictive failure not raised");
  AST_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
    fail_q[1] > ERR_THRESH |-> 1'b0) else $error("failure count left over threshold");
  AST_REF_CLAMP: assert property (@(posedge clk_i) disable iff (rst_i)
    ref_q <= TRIP_FIXED_C) else $error("reference above fixed trip");
  AST_PUSH: assert property (@(posedge clk_i) disable iff (rst_i)
    push |=> log_q[0].result == RES_IN_PROGRESS && log_store_o)
    else $error("new entry not in progress");
  AST_ABORT: assert property (@(posedge clk_i) disable iff (rst_i)
    (test_busy_o && st_q != ST_DONE && bus_reset_i) |=> log_q[0].result == RES_ABORT_RESET)
    else $error("reset abort not logged");
  AST_SEQ: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == ST_ELEC) |=> (st_q inside {ST_ELEC, ST_SERVO, ST_DONE}))
    else $error("segment order broken");
  AST_WARN: assert property (@(posedge clk_i) disable iff (rst_i)
    (sense_o.code == SENSE_TEMP_WARN && sense_o.valid) |-> $past(warning_enable_i))
    else $error("warning sent while disabled");
  COV_SHORT: cover property (@(posedge clk_i) push && req == FUNC_SHORT);
  COV_DONE: cover property (@(posedge clk_i) fin && fin_res == RES_PASS);
  COV_HOT: cover property (@(posedge clk_i) sense_o.code == SENSE_TEMP_WARN);
endmodule : dhm_top

//--- common/dhm_pkg.sv
package dhm_pkg;
  localparam int          NUM_ATTR          = 4;
  localparam int          CNT_W             = 16;
  localparam int          HIST_W            = 8;
  localparam int          TEMP_W            = 8;
  localparam int          LOG_DEPTH         = 20;
  localparam logic [7:0]  TRIP_FIXED_C      = 8'h44;
  localparam logic [7:0]  TRIP_DEFAULT_C    = 8'h44;
  localparam logic [2:0]  REPORT_PREDICT    = 3'h1;
  localparam logic [23:0] SENSE_PREDICT     = 24'h015d00;
  localparam logic [23:0] SENSE_TEMP_WARN   = 24'h010b01;
  localparam logic [23:0] SENSE_ROUNDED     = 24'h013700;
  localparam logic [23:0] SENSE_NOT_READY   = 24'h020400;
  localparam logic [23:0] SENSE_NOT_READY_3 = 24'h020403;
  localparam logic [15:0] TLOG_CUR_TEMP     = 16'h0000;
  localparam logic [15:0] TLOG_REF_TEMP     = 16'h0001;
  localparam logic [2:0]  FUNC_SHORT        = 3'h1;
  localparam logic [2:0]  FUNC_EXTENDED     = 3'h2;
  localparam logic [2:0]  FUNC_ABORT        = 3'h4;
  localparam int          FUNC_LSB          = 5;
  localparam logic [3:0]  RES_PASS          = 4'h0;
  localparam logic [3:0]  RES_ABORT_APP     = 4'h1;
  localparam logic [3:0]  RES_ABORT_RESET   = 4'h2;
  localparam logic [3:0]  RES_SEG_FAIL      = 4'h3;
  localparam logic [3:0]  RES_IN_PROGRESS   = 4'hf;
  localparam longint      CLK_HZ            = 100000000;
  localparam longint      TEMP_PERIOD_MIN   = 10;
  localparam longint      TEMP_PERIOD_CYC   = TEMP_PERIOD_MIN * 60 * CLK_HZ;
  localparam longint      SHORT_LIMIT_S     = 120;
  localparam longint      SHORT_LIMIT_CYC   = SHORT_LIMIT_S * CLK_HZ;

  typedef struct packed {
    logic [2:0] func;
    logic [3:0] result;
  } dhm_log_t;

  typedef struct packed {
    logic        valid;
    logic [23:0] code;
    logic [7:0]  unit_code;
  } dhm_sense_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_ELEC  = 5'h02,
    ST_SERVO = 5'h04,
    ST_SCAN  = 5'h08,
    ST_DONE  = 5'h10
  } dhm_state_t;
endpackage : dhm_pkg

//--- testbench/dhm_host_model.sv
`timescale 1ns/10ps
// Host side of the drive interface: issues diagnostic commands and trip point writes.
module dhm_host_model (
  input  wire logic       clk_i,
  output logic            diag_cmd_o,
  output logic [7:0]      diag_byte1_o,
  output logic            ref_wr_o,
  output logic [7:0]      ref_wdata_o
);
  initial begin
    diag_cmd_o   = 1'b0;
    diag_byte1_o = 8'h00;
    ref_wr_o     = 1'b0;
    ref_wdata_o  = 8'h00;
  end

  // Released fields are inverted so a stale value is never mistaken for a command.
  task automatic send_diag(input logic [2:0] func);
    @(negedge clk_i);
    diag_cmd_o   = 1'b1;
    diag_byte1_o = {func, 5'h00};
    @(negedge clk_i);
    diag_cmd_o   = 1'b0;
    diag_byte1_o = ~diag_byte1_o;
  endtask : send_diag

  task automatic write_ref(input logic [7:0] val);
    @(negedge clk_i);
    ref_wr_o    = 1'b1;
    ref_wdata_o = val;
    @(negedge clk_i);
    ref_wr_o    = 1'b0;
    ref_wdata_o = ~ref_wdata_o;
  endtask : write_ref
endmodule : dhm_host_model

//--- testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import dhm_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic bus_reset_i, exception_disable_i, warning_enable_i, seg_fail_i;
  logic motor_fail_i, servo_fail_i, table_fail_i, diag_cmd_i, ref_wr_i;
  logic [NUM_ATTR-1:0] op_done_i, op_err_i, pred_attr_o;
  logic [2:0]  report_method_field_i;
  logic [7:0]  temp_i, ref_wdata_i, diag_byte1_i, tlog_data_o, ref_temp_o;
  logic [15:0] tlog_code_i;
  logic [4:0]  log_idx_i;
  logic [23:0] ready_code_o;
  logic        pred_fail_o, test_busy_o, log_store_o;
  dhm_sense_t  sense_o, last_sense;
  dhm_state_t  test_state_o;
  dhm_log_t    log_entry_o;
  dhm_state_t  st_q[$];
  int          bad_count = 0;
  int          n_checks = 0;
  int          store_cnt = 0;

  always #5 clk_i = ~clk_i;

  // Monitoring thresholds keep their defaults; only the long time spans are shortened.
  dhm_top #(.TEMP_PERIOD(64'h64), .SHORT_LIMIT(64'h64), .SEG_CYC_SHORT(32'h8),
    .SEG_CYC_EXT(32'h10))
  i_dhm_top (.clk_i(clk_i), .rst_i(rst_i), .bus_reset_i(bus_reset_i), .op_done_i(op_done_i),
    .op_err_i(op_err_i), .exception_disable_i(exception_disable_i),
    .warning_enable_i(warning_enable_i), .report_method_field_i(report_method_field_i),
    .temp_i(temp_i), .ref_wr_i(ref_wr_i), .ref_wdata_i(ref_wdata_i),
    .tlog_code_i(tlog_code_i), .diag_cmd_i(diag_cmd_i), .diag_byte1_i(diag_byte1_i),
    .seg_fail_i(seg_fail_i), .motor_fail_i(motor_fail_i), .servo_fail_i(servo_fail_i),
    .table_fail_i(table_fail_i), .log_idx_i(log_idx_i), .pred_fail_o(pred_fail_o),
    .pred_attr_o(pred_attr_o), .sense_o(sense_o), .tlog_data_o(tlog_data_o),
    .ref_temp_o(ref_temp_o), .test_busy_o(test_busy_o), .test_state_o(test_state_o),
    .log_entry_o(log_entry_o), .log_store_o(log_store_o), .ready_code_o(ready_code_o));

  dhm_host_model i_dhm_host_model (.clk_i(clk_i), .diag_cmd_o(diag_cmd_i),
    .diag_byte1_o(diag_byte1_i), .ref_wr_o(ref_wr_i), .ref_wdata_o(ref_wdata_i));

  // The sense output stands one cycle, so it is latched here for later comparison.
  always @(posedge clk_i) begin
    if (sense_o.valid === 1'b1) last_sense = sense_o;
    if (log_store_o === 1'b1) store_cnt++;
    if (st_q.size() == 0 || test_state_o !== st_q[$]) st_q.push_back(test_state_o);
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (bad_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc

  task automatic op(input int a, input logic err);
    op_done_i[a] = 1'b1;
    op_err_i[a]  = err;
    cyc(1);
    op_done_i = '0;
    op_err_i  = '0;
    cyc(1);
  endtask : op

  // Seventeen errors exceed the default threshold of sixteen; 1024 clean ops end an interval.
  task automatic unacc(input int a);
    repeat (17) op(a, 1'b1);
  endtask : unacc

  task automatic acc(input int a);
    repeat (1024) op(a, 1'b0);
  endtask : acc

  // Kind 0 runs to the end, 1 aborts by command, 2 by bus reset, 3 fails a segment.
  task automatic run_test(input logic [2:0] f, input int kind, input logic [3:0] res);
    int k;
    int s0;
    dhm_state_t seq[6];
    seq = '{ST_IDLE, ST_ELEC, ST_SERVO, ST_SCAN, ST_DONE, ST_IDLE};
    s0 = store_cnt;
    st_q.delete();
    i_dhm_host_model.send_diag(f);
    k = 0;
    while (test_busy_o !== 1'b1 && k < 5) begin
      cyc(1);
      k++;
    end
    cyc(1);
    chk(32'(log_entry_o), 32'({f, RES_IN_PROGRESS}));
    if (kind == 1) i_dhm_host_model.send_diag(FUNC_ABORT);
    if (kind == 2) bus_reset_i = 1'b1;
    if (kind == 3) seg_fail_i = 1'b1;
    k = 0;
    while (test_busy_o !== 1'b0 && k < 100) begin
      cyc(1);
      k++;
    end
    bus_reset_i = 1'b0;
    seg_fail_i  = 1'b0;
    chk(32'(test_busy_o), 32'h0);
    cyc(2);
    chk(32'(log_entry_o), 32'({f, res}));
    chk(32'(store_cnt - s0), 32'h2);
    if (kind == 0) for (int i = 0; i < 6; i++) chk(32'(st_q[i]), 32'(seq[i]));
  endtask : run_test

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    close_out();
  end

  initial begin
    logic [23:0] rdy[4];
    rdy = '{24'h0, SENSE_NOT_READY, SENSE_NOT_READY_3, SENSE_NOT_READY};
    {bus_reset_i, exception_disable_i, seg_fail_i, motor_fail_i} = '0;
    {servo_fail_i, table_fail_i, op_done_i, op_err_i, log_idx_i} = '0;
    warning_enable_i      = 1'b1;
    report_method_field_i = REPORT_PREDICT;
    temp_i                = 8'h30;
    tlog_code_i           = TLOG_CUR_TEMP;
    last_sense            = '0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    chk(32'(ref_temp_o), 32'(TRIP_DEFAULT_C));
    chk(32'({pred_fail_o, pred_attr_o}), 32'h0);
    cyc(20);
    chk(32'(tlog_data_o), 32'h30);
    tlog_code_i = TLOG_REF_TEMP;
    cyc(2);
    chk(32'(tlog_data_o), 32'h44);
    i_dhm_host_model.write_ref(8'h50);
    cyc(3);
    chk(32'(ref_temp_o), 32'h44);
    chk(32'(last_sense.code), 32'(SENSE_ROUNDED));
    i_dhm_host_model.write_ref(8'h20);
    cyc(3);
    chk(32'(ref_temp_o), 32'h20);
    last_sense = '0;
    cyc(130);
    chk(32'({last_sense.code, last_sense.unit_code}), 32'({SENSE_TEMP_WARN, 8'h30}));
    warning_enable_i = 1'b0;
    cyc(2);
    last_sense = '0;
    cyc(130);
    chk(32'(last_sense.valid), 32'h0);
    warning_enable_i      = 1'b1;
    report_method_field_i = 3'h0;
    cyc(2);
    last_sense = '0;
    cyc(130);
    chk(32'(last_sense.valid), 32'h0);
    report_method_field_i = REPORT_PREDICT;
    temp_i = 8'h10;
    exception_disable_i = 1'b1;
    repeat (3) unacc(2);
    exception_disable_i = 1'b0;
    cyc(2);
    chk(32'(pred_attr_o), 32'h0);
    // An acceptable interval at zero history must not wrap the counter.
    acc(1);
    repeat (7) unacc(1);
    acc(1);
    unacc(1);
    cyc(2);
    chk(32'(pred_fail_o), 32'h0);
    last_sense = '0;
    unacc(1);
    cyc(2);
    chk(32'({pred_fail_o, pred_attr_o}), 32'h12);
    chk(32'({last_sense.code, last_sense.unit_code}), 32'({SENSE_PREDICT, 8'h02}));
    i_dhm_host_model.send_diag(3'h0);
    bus_reset_i = 1'b1;
    cyc(1);
    bus_reset_i = 1'b0;
    cyc(2);
    chk(32'(pred_attr_o), 32'h2);
    for (int i = 0; i < 4; i++) begin
      motor_fail_i = (i == 1);
      servo_fail_i = (i == 2);
      table_fail_i = (i == 3);
      cyc(3);
      chk(32'(ready_code_o), 32'(rdy[i]));
    end
    table_fail_i = 1'b0;
    run_test(FUNC_SHORT, 0, RES_PASS);
    run_test(FUNC_EXTENDED, 0, RES_PASS);
    run_test(FUNC_EXTENDED, 1, RES_ABORT_APP);
    run_test(FUNC_EXTENDED, 2, RES_ABORT_RESET);
    run_test(FUNC_SHORT, 3, RES_SEG_FAIL);
    repeat (16) run_test(FUNC_SHORT, 0, RES_PASS);
    log_idx_i = 5'd19;
    cyc(2);
    chk(32'(log_entry_o), 32'({FUNC_EXTENDED, RES_PASS}));
    log_idx_i = 5'd20;
    cyc(2);
    chk(32'(log_entry_o), 32'h0);
    close_out();
  end
endmodule : tb_top
